// file: common/sdsf_consts.vh
// register map, field positions and reset values of the sinc filter bank
`ifndef SDSF_CONSTS_VH
`define SDSF_CONSTS_VH
// address map: channel c at c*0x20, word index in haddr[4:2]; globals at 0x100
`define SDSF_GLOBAL_BIT 8
`define SDSF_REG_CTRL 3'h0
`define SDSF_REG_DPARM 3'h1
`define SDSF_REG_CPARM 3'h2
`define SDSF_REG_CMPH 3'h3
`define SDSF_REG_CMPL 3'h4
`define SDSF_REG_STAT 3'h5
`define SDSF_REG_DATA 3'h6
`define SDSF_REG_FDATA 3'h0
`define SDSF_REG_FSTAT 3'h1
// control fields
`define SDSF_CTRL_EN 0
`define SDSF_CTRL_MODE_LSB 1
`define SDSF_CTRL_HALF_LSB 8
// filter parameter fields (order and ratio in both filters; 16-bit form and shift in the data filter only)
`define SDSF_PARM_ORD_LSB 0
`define SDSF_PARM_OSR_LSB 8
`define SDSF_PARM_M16 16
`define SDSF_PARM_SH_LSB 20
// status bits
`define SDSF_ST_RDY 0
`define SDSF_ST_HI 1
`define SDSF_ST_LO 2
`define SDSF_ST_OVR 3
// input modes
`define SDSF_MODE_EQ 2'h0
`define SDSF_MODE_DBL 2'h1
`define SDSF_MODE_MAN 2'h2
`define SDSF_MODE_HALF 2'h3
// filter orders
`define SDSF_ORD_FAST 2'h0
`define SDSF_ORD_1 2'h1
`define SDSF_ORD_2 2'h2
`define SDSF_ORD_3 2'h3
// reset values
`define SDSF_CTRL_RST 32'h0000_0400
`define SDSF_DPARM_RST 32'h0000_FF03
`define SDSF_CPARM_RST 32'h0000_1F03
`define SDSF_CMPH_RST 32'h7FFF_FFFF
`define SDSF_CMPL_RST 32'h8000_0000
`endif

// file: rtl/sdsf_bank.v
// sigma-delta sinc filter bank: fifo, sinc filter and the bank top
// ---------------------------------------------------------------
// How it works
// - the bank holds two filter modules of four independent channels each, eight in total.
// - the input stage takes data at the link clock rate, twice it, half it, or Manchester coded.
// - a modulator giving one bit per clock is served by input mode 0.
// - in Manchester mode data is recovered from the data pin alone, with no clock pin.
// - the filters offer sinc1, sinc2, sinc3 and a fast sinc, with ratio 1 to 256.
// - a filter emits one sample per ratio count of input bits.
// - each data result lands in a result register that software reads.
// - the result is 32 bits wide, with a selectable 16-bit form.
// - the 16-bit form is the 32-bit value shifted right arithmetically by a programmed amount.
// - peak outputs are x, x squared, x cubed and two x squared for ratio x.
// - sinc3 at ratio 256 yields 24 bits of resolution.
// - each channel has a second, independent comparator filter on the same bits.
// - the comparator checks its value against per-channel high and low thresholds.
// - the comparator serves overvoltage and short-circuit detection.
// ---------------------------------------------------------------
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "sdsf_consts.vh"

// ---------------------------------------------------------------
// result fifo
// ---------------------------------------------------------------
module sdsf_fifo #(
  parameter WIDTH = 35,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             rstB,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0]      level
);
  reg [WIDTH-1:0] memQ [0:DEPTH-1];
  reg [AW-1:0]    wrPtrQ;
  reg [AW-1:0]    rdPtrQ;
  reg [AW:0]      cntQ;
  wire            push = inValid & inReady;
  wire            pop  = outValid & outReady;

  assign inReady  = (cntQ != DEPTH[AW:0]);
  assign outValid = (cntQ != {(AW+1){1'b0}});
  assign outData  = memQ[rdPtrQ];
  assign level    = cntQ;

  // pointers wrap at depth, which must be a power of two
  always @(posedge clk)
  begin
    if (!rstB)
    begin
      wrPtrQ <= {AW{1'b0}};
      rdPtrQ <= {AW{1'b0}};
      cntQ   <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        memQ[wrPtrQ] <= inData;
        wrPtrQ       <= wrPtrQ + 1'b1;
      end
      if (pop)
        rdPtrQ <= rdPtrQ + 1'b1;
      if (push & ~pop)
        cntQ <= cntQ + 1'b1;
      else if (pop & ~push)
        cntQ <= cntQ - 1'b1;
    end
  end
endmodule

// ---------------------------------------------------------------
// sinc filter: three integrators, decimation, up to three combs
// ---------------------------------------------------------------
module sdsf_sinc (
  input  wire        clk,
  input  wire        rstB,
  input  wire        en,
  input  wire        bitValid,
  input  wire        bitVal,
  input  wire [1:0]  order,
  input  wire [7:0]  osrM1,
  output reg         outValid,
  output reg  [31:0] outVal
);
  reg  [31:0] i1Q, i2Q, i3Q, d1Q, d2Q, d3Q;
  reg  [7:0]  decQ;
  reg  [31:0] tap;
  wire [31:0] x  = bitVal ? 32'h0000_0001 : 32'hFFFF_FFFF;
  wire [31:0] c1 = tap - d1Q;
  wire [31:0] c2 = c1 - d2Q;
  wire [31:0] c3 = c2 - d3Q;

  // integrator tap feeding the combs, by order
  always @*
  begin
    case (order)
      `SDSF_ORD_1: tap = i1Q;
      `SDSF_ORD_3: tap = i3Q;
      default:     tap = i2Q;
    endcase
  end

  // wraparound arithmetic is exact as long as peaks fit 32 bits
  always @(posedge clk)
  begin
    if (!rstB || !en)
    begin
      {i1Q, i2Q, i3Q, d1Q, d2Q, d3Q} <= {6{32'h0000_0000}};
      decQ     <= 8'h00;
      outValid <= 1'b0;
      outVal   <= 32'h0000_0000;
    end
    else
    begin
      outValid <= 1'b0;
      if (bitValid)
      begin
        i1Q <= i1Q + x;
        i2Q <= i2Q + i1Q + x;
        i3Q <= i3Q + i2Q + i1Q + x;
        decQ <= (decQ == osrM1) ? 8'h00 : decQ + 8'h01;
        if (decQ == osrM1)
        begin
          d1Q      <= tap;
          d2Q      <= c1;
          d3Q      <= c2;
          outValid <= 1'b1;
          case (order)
            `SDSF_ORD_1: outVal <= c1;
            `SDSF_ORD_2: outVal <= c2;
            `SDSF_ORD_3: outVal <= c3;
            default:     outVal <= {c2[30:0], 1'b0};
          endcase
        end
      end
    end
  end
endmodule

// ---------------------------------------------------------------
// bank top with AHB-Lite register slave
// ---------------------------------------------------------------
module sdsf_bank #(
  parameter NUM_MOD  = 2,
  parameter CH_PER   = 4,
  parameter FIFO_DEP = 32
) (
  input  wire                        core_clk,
  input  wire                        rst_b,
  input  wire                        hsel,
  input  wire [11:0]                 haddr,
  input  wire [1:0]                  htrans,
  input  wire                        hwrite,
  input  wire [2:0]                  hsize,
  input  wire                        hready,
  input  wire [31:0]                 hwdata,
  output reg  [31:0]                 hrdata,
  output reg                         hreadyout,
  output reg                         hresp,
  input  wire [NUM_MOD*CH_PER-1:0]   sdClk,
  input  wire [NUM_MOD*CH_PER-1:0]   sdData,
  output reg  [NUM_MOD*CH_PER-1:0]   cmpAlert
);
  localparam NCH = NUM_MOD * CH_PER;

  // register storage, addressed by channel index
  reg  [31:0] ctrlQ  [0:NCH-1];
  reg  [31:0] dparmQ [0:NCH-1];
  reg  [31:0] cparmQ [0:NCH-1];
  reg  [31:0] cmphQ  [0:NCH-1];
  reg  [31:0] cmplQ  [0:NCH-1];
  reg  [31:0] dataQ  [0:NCH-1];
  reg  [3:0]  statQ  [0:NCH-1];
  reg  [31:0] pendDataQ [0:NCH-1];
  reg  [NCH-1:0] pendQ;
  // data phase state
  reg         wrPendQ;
  reg  [8:0]  wrAddrQ;
  // per-channel events from the datapath
  wire [NCH-1:0] resEv, hiEv, loEv;
  wire [31:0]    resVal [0:NCH-1];
  // fifo link
  reg  [2:0]  pushCh;
  reg         pushAny;
  wire        fifoInReady, fifoOutValid;
  wire [34:0] fifoOut;
  wire [5:0]  fifoLevel;

  wire        take    = hsel & htrans[1] & hready;
  wire [8:0]  rdAddr  = haddr[10:2];
  wire [2:0]  rdCh    = haddr[7:5];
  wire        rdGlob  = haddr[`SDSF_GLOBAL_BIT];
  wire        rdMapped = (haddr[11:9] == 3'h0) & ~(rdGlob & (haddr[7:3] != 5'h00));
  wire        popNow  = take & ~hwrite & rdMapped & rdGlob & (haddr[4:2] == `SDSF_REG_FDATA);

  // ---------------------------------------------------------------
  // channel datapath
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : ch
      reg  clkS1, clkS2, clkS3, datS1, datS2, datS3;
      reg  bitValidQ, bitValQ, phaseQ;
      reg  [8:0] manCntQ;
      wire en   = ctrlQ[gi][`SDSF_CTRL_EN];
      wire [1:0] mode = ctrlQ[gi][`SDSF_CTRL_MODE_LSB+1:`SDSF_CTRL_MODE_LSB];
      wire [7:0] half = ctrlQ[gi][`SDSF_CTRL_HALF_LSB+7:`SDSF_CTRL_HALF_LSB];
      wire rise = clkS2 & ~clkS3;
      wire fall = ~clkS2 & clkS3;
      wire datEdge = datS2 ^ datS3;
      wire dV, cV;
      wire [31:0] dOut, cOut;
      wire [31:0] cmpH = cmphQ[gi];
      wire [31:0] cmpL = cmplQ[gi];
      wire [4:0]  sh = dparmQ[gi][`SDSF_PARM_SH_LSB+4:`SDSF_PARM_SH_LSB];
      wire [31:0] shifted = $signed(dOut) >>> sh;

      // pins cross into core_clk through two flops before any use
      always @(posedge core_clk)
      begin
        {clkS3, clkS2, clkS1} <= {clkS2, clkS1, sdClk[gi]};
        {datS3, datS2, datS1} <= {datS2, datS1, sdData[gi]};
      end

      // input control: picks the bit strobe by mode
      always @(posedge core_clk)
      begin
        if (!rst_b || !en)
        begin
          bitValidQ <= 1'b0;
          bitValQ   <= 1'b0;
          phaseQ    <= 1'b0;
          manCntQ   <= 9'h000;
        end
        else
        begin
          bitValQ <= datS2;
          case (mode)
            `SDSF_MODE_EQ:   bitValidQ <= rise;
            `SDSF_MODE_DBL:  bitValidQ <= rise | fall;
            `SDSF_MODE_HALF:
            begin
              bitValidQ <= rise & phaseQ;
              if (rise)
                phaseQ <= ~phaseQ;
            end
            default:
            begin
              // mid-bit edge opens a 1.5 half-bit blind window over the boundary edge
              bitValidQ <= datEdge & (manCntQ == 9'h000);
              if (datEdge && manCntQ == 9'h000)
                manCntQ <= {1'b0, half} + {2'b00, half[7:1]};
              else if (manCntQ != 9'h000)
                manCntQ <= manCntQ - 9'h001;
            end
          endcase
        end
      end

      // data filter and independent comparator filter on one bit stream
      sdsf_sinc dFilt (
        .clk      (core_clk),
        .rstB     (rst_b),
        .en       (en),
        .bitValid (bitValidQ),
        .bitVal   (bitValQ),
        .order    (dparmQ[gi][`SDSF_PARM_ORD_LSB+1:`SDSF_PARM_ORD_LSB]),
        .osrM1    (dparmQ[gi][`SDSF_PARM_OSR_LSB+7:`SDSF_PARM_OSR_LSB]),
        .outValid (dV),
        .outVal   (dOut)
      );
      sdsf_sinc cFilt (
        .clk      (core_clk),
        .rstB     (rst_b),
        .en       (en),
        .bitValid (bitValidQ),
        .bitVal   (bitValQ),
        .order    (cparmQ[gi][`SDSF_PARM_ORD_LSB+1:`SDSF_PARM_ORD_LSB]),
        .osrM1    (cparmQ[gi][`SDSF_PARM_OSR_LSB+7:`SDSF_PARM_OSR_LSB]),
        .outValid (cV),
        .outVal   (cOut)
      );

      // result form and threshold compare, signed
      assign resEv[gi]  = dV;
      assign resVal[gi] = dparmQ[gi][`SDSF_PARM_M16] ?
                          {{16{shifted[15]}}, shifted[15:0]} : dOut;
      assign hiEv[gi]   = cV & ($signed(cOut) > $signed(cmpH));
      assign loEv[gi]   = cV & ($signed(cOut) < $signed(cmpL));
    end
  endgenerate

  // ---------------------------------------------------------------
  // fifo feed: lowest pending channel first
  // ---------------------------------------------------------------
  integer k;
  always @*
  begin
    pushAny = 1'b0;
    pushCh  = 3'h0;
    for (k = NCH - 1; k >= 0; k = k - 1)
      if (pendQ[k])
      begin
        pushAny = 1'b1;
        pushCh  = k[2:0];
      end
  end

  sdsf_fifo #(.WIDTH(35), .DEPTH(FIFO_DEP), .AW(5)) resFifo (
    .clk      (core_clk),
    .rstB     (rst_b),
    .inValid  (pushAny),
    .inReady  (fifoInReady),
    .inData   ({pushCh, pendDataQ[pushCh]}),
    .outValid (fifoOutValid),
    .outReady (popNow),
    .outData  (fifoOut),
    .level    (fifoLevel)
  );

  // ---------------------------------------------------------------
  // read mux; a read right after a write to a ctrl, parameter or threshold register sees the written word
  // ---------------------------------------------------------------
  reg [31:0] rdVal;
  always @*
  begin
    rdVal = 32'h0000_0000;
    if (rdMapped && rdGlob)
      rdVal = (haddr[4:2] == `SDSF_REG_FDATA) ? fifoOut[31:0] :
              {fifoOutValid, 20'h00000, fifoLevel, 2'b00, fifoOut[34:32]};
    else if (rdMapped)
      case (haddr[4:2])
        `SDSF_REG_CTRL:  rdVal = ctrlQ[rdCh];
        `SDSF_REG_DPARM: rdVal = dparmQ[rdCh];
        `SDSF_REG_CPARM: rdVal = cparmQ[rdCh];
        `SDSF_REG_CMPH:  rdVal = cmphQ[rdCh];
        `SDSF_REG_CMPL:  rdVal = cmplQ[rdCh];
        `SDSF_REG_STAT:  rdVal = {28'h0000000, statQ[rdCh]};
        `SDSF_REG_DATA:  rdVal = dataQ[rdCh];
        default:         rdVal = 32'h0000_0000;
      endcase
    if (wrPendQ && rdMapped && wrAddrQ == rdAddr && !rdGlob && haddr[4:2] < `SDSF_REG_STAT)
      rdVal = hwdata;
  end

  // ---------------------------------------------------------------
  // bus slave, registers, flags; set always beats clear
  // ---------------------------------------------------------------
  integer c;
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendQ   <= 1'b0;
      wrAddrQ   <= 9'h000;
      pendQ     <= {NCH{1'b0}};
      cmpAlert  <= {NCH{1'b0}};
      for (c = 0; c < NCH; c = c + 1)
      begin
        ctrlQ[c]     <= `SDSF_CTRL_RST;
        dparmQ[c]    <= `SDSF_DPARM_RST;
        cparmQ[c]    <= `SDSF_CPARM_RST;
        cmphQ[c]     <= `SDSF_CMPH_RST;
        cmplQ[c]     <= `SDSF_CMPL_RST;
        dataQ[c]     <= 32'h0000_0000;
        statQ[c]     <= 4'h0;
        pendDataQ[c] <= 32'h0000_0000;
      end
    end
    else
    begin
      // zero-wait slave: always ready, always OKAY
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPendQ   <= take & hwrite & rdMapped & ~rdGlob;
      wrAddrQ   <= rdAddr;
      if (take && !hwrite)
        hrdata <= rdVal;
      for (c = 0; c < NCH; c = c + 1)
      begin
        // writes land in the data phase
        if (wrPendQ && wrAddrQ[5:3] == c[2:0])
          case (wrAddrQ[2:0])
            `SDSF_REG_CTRL:  ctrlQ[c]  <= hwdata;
            `SDSF_REG_DPARM: dparmQ[c] <= hwdata;
            `SDSF_REG_CPARM: cparmQ[c] <= hwdata;
            `SDSF_REG_CMPH:  cmphQ[c]  <= hwdata;
            `SDSF_REG_CMPL:  cmplQ[c]  <= hwdata;
            `SDSF_REG_STAT:  statQ[c]  <= statQ[c] & ~hwdata[3:0];
            default:         ;
          endcase
        // reading the result clears ready
        if (take && !hwrite && rdMapped && !rdGlob && rdCh == c[2:0] &&
            haddr[4:2] == `SDSF_REG_DATA)
          statQ[c][`SDSF_ST_RDY] <= 1'b0;
        if (pushAny && fifoInReady && pushCh == c[2:0])
          pendQ[c] <= 1'b0;
        if (resEv[c])
        begin
          dataQ[c]               <= resVal[c];
          pendDataQ[c]           <= resVal[c];
          pendQ[c]               <= 1'b1;
          statQ[c][`SDSF_ST_RDY] <= 1'b1;
          // fifo stall left an older result unsent: it is overwritten
          if (pendQ[c] && !(pushAny && fifoInReady && pushCh == c[2:0]))
            statQ[c][`SDSF_ST_OVR] <= 1'b1;
        end
        if (hiEv[c])
          statQ[c][`SDSF_ST_HI] <= 1'b1;
        if (loEv[c])
          statQ[c][`SDSF_ST_LO] <= 1'b1;
        // alert pin follows the sticky fault flags
        cmpAlert[c] <= statQ[c][`SDSF_ST_HI] | statQ[c][`SDSF_ST_LO];
      end
    end
  end
endmodule

// file: test/sdsf_bank_assertions.sv
// port-level checks of the sinc filter bank
`timescale 1ns/1ps
module sdsf_bank_assertions #(
  parameter NUM_MOD = 2,
  parameter CH_PER  = 4
) (
  input wire logic                      core_clk,
  input wire logic                      rst_b,
  input wire logic                      hsel,
  input wire logic [11:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic [31:0]               hwdata,
  input wire logic [31:0]               hrdata,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire logic [NUM_MOD*CH_PER-1:0] cmpAlert
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  wire         take = hsel & htrans[1] & hready;
  wire         wrTake = take & hwrite;
  wire         rdTake = take & !hwrite;
  logic        cmphWr_q;
  logic [31:0] cmph_q;
  logic [3:0]  wrHist_q;
  // shadow of channel 0 high threshold; a clear lands a few cycles after its write
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cmphWr_q <= 1'h0;
      cmph_q   <= 32'h7FFF_FFFF;
      wrHist_q <= 4'h0;
    end
    else
    begin
      cmphWr_q <= wrTake & (haddr == 12'h00C);
      cmph_q   <= cmphWr_q ? hwdata : cmph_q;
      wrHist_q <= {wrHist_q[2:0], wrTake};
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (take |=> !hresp)
    else $error("response not okay");
  a_reset_quiet: assert property ($rose(rst_b) |-> cmpAlert == '0 && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_rdata_hold: assert property (!rdTake |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rdTake && haddr[11:9] != 3'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_stat_width: assert property (rdTake && haddr[11:8] == 4'h0 && haddr[4:0] == 5'h14
    |=> hrdata[31:4] == 28'h0)
    else $error("status has stray bits");
  a_cmph_back: assert property (rdTake && haddr == 12'h00C |=> hrdata == cmph_q)
    else $error("high threshold readback wrong");
  a_alert_clear: assert property (|($past(cmpAlert) & ~cmpAlert) |-> |wrHist_q)
    else $error("alert dropped without a write");
  // main scenarios reached
  c_alert: cover property ($rose(|cmpAlert));
  c_unmapped: cover property (rdTake && haddr[11:9] != 3'h0);
  c_back: cover property (wrTake ##2 (rdTake && haddr == 12'h00C));
endmodule
bind sdsf_bank sdsf_bank_assertions #(.NUM_MOD(NUM_MOD), .CH_PER(CH_PER)) sdsf_bank_assertions_i (
  .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cmpAlert(cmpAlert));

// file: test/sdsf_bank_bench.sv
// self-checking bench for the sinc filter bank
`timescale 1ns/1ps
`include "sdsf_consts.vh"
module sdsf_bank_bench;
  logic        core_clk, rst_b, hwrite, run, man, ones;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, rd;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [7:0]  sdClk, sdData, cmpAlert;
  int          err_count, samples_checked;
  // ---------------------------------------------------------------
  // design and modulator
  // ---------------------------------------------------------------
  sdsf_bank sdsf_bank_i (.core_clk(core_clk), .rst_b(rst_b), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .sdClk(sdClk), .sdData(sdData),
    .cmpAlert(cmpAlert));
  sdsf_mod_model sdsf_mod_model_i (.run(run), .man(man), .ones(ones), .sdClk(sdClk),
    .sdData(sdData));
  // 200 MHz core clock
  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single AHB transfer; waits on hready with no cycle count assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // pull n results of channel 0; the last one stays in rd
  task automatic res(input int n);
    repeat (n)
    begin
      do bus(1'h0, 12'h014, 32'h0); while (rd[0] !== 1'h1);
      bus(1'h0, 12'h018, 32'h0);
    end
  endtask
  // disabling first restarts the filters, so settling outputs are predictable
  task automatic setup(input logic [1:0] md, input logic [31:0] dp, input logic [31:0] cp);
    // coding picked while idle: a stray pin edge lands before the channel is enabled
    run <= 1'h0;
    man <= (md == `SDSF_MODE_MAN);
    wr(12'h000, 32'h0);
    wr(12'h004, dp);
    wr(12'h008, cp);
    wr(12'h014, 32'hF);
    wr(12'h000, {16'h0, 8'h05, 5'h0, md, 1'h1});
    run <= 1'h1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rdchk(12'h060, `SDSF_CTRL_RST);
    rdchk(12'h064, `SDSF_DPARM_RST);
    rdchk(12'h068, `SDSF_CPARM_RST);
    rdchk(12'h06C, `SDSF_CMPH_RST);
    rdchk(12'h070, `SDSF_CMPL_RST);
    rdchk(12'h0F4, 32'h0);
    rdchk(12'h104, 32'h0);
    wr(12'hE04, 32'hFFFF_FFFF);
    rdchk(12'hE04, 32'h0);
    wr(12'h00C, 32'h1234_5678);
    rdchk(12'h00C, 32'h1234_5678);
    $display("test reset done");
  endtask
  task automatic t_modes;
    logic [1:0] md [4] = '{`SDSF_MODE_EQ, `SDSF_MODE_DBL, `SDSF_MODE_HALF, `SDSF_MODE_MAN};
    ones <= 1'h1;
    foreach (md[i])
    begin
      setup(md[i], 32'h0000_0301, `SDSF_CPARM_RST);
      res(5);
      chk(rd, 32'h4);
    end
    $display("test modes done");
  endtask
  task automatic t_orders;
    logic [1:0]  od [4] = '{`SDSF_ORD_FAST, `SDSF_ORD_1, `SDSF_ORD_2, `SDSF_ORD_3};
    logic [31:0] pk [4] = '{32'h20, 32'h4, 32'h10, 32'h40};
    ones <= 1'h1;
    foreach (od[i])
    begin
      setup(`SDSF_MODE_EQ, {16'h0, 8'h03, 6'h0, od[i]}, `SDSF_CPARM_RST);
      res(5);
      chk(rd, pk[i]);
    end
    ones <= 1'h0;
    setup(`SDSF_MODE_EQ, 32'h0000_0303, `SDSF_CPARM_RST);
    res(5);
    chk(rd, 32'hFFFF_FFC0);
    // 16-bit form, shift 2 puts the top of a 7-bit peak where software wants it
    setup(`SDSF_MODE_EQ, 32'h0021_0303, `SDSF_CPARM_RST);
    res(5);
    chk(rd, 32'hFFFF_FFF0);
    ones <= 1'h1;
    setup(`SDSF_MODE_EQ, 32'h0021_0303, `SDSF_CPARM_RST);
    res(5);
    chk(rd, 32'h10);
    setup(`SDSF_MODE_EQ, `SDSF_DPARM_RST, `SDSF_CPARM_RST);
    res(5);
    chk(rd, 32'h0100_0000);
    $display("test orders done");
  endtask
  task automatic t_cmp;
    wr(12'h00C, 32'h3);
    wr(12'h010, 32'hFFFF_FFFD);
    ones <= 1'h1;
    setup(`SDSF_MODE_EQ, 32'h0000_0301, 32'h0000_0301);
    res(5);
    bus(1'h0, 12'h014, 32'h0);
    chk(rd & 32'h6, 32'h2);
    chk({24'h0, cmpAlert}, 32'h1);
    wr(12'h000, 32'h0);
    // overrun is set too: the result fifo is never drained before the fifo test
    wr(12'h014, 32'hF);
    rdchk(12'h014, 32'h0);
    chk({24'h0, cmpAlert}, 32'h0);
    ones <= 1'h0;
    setup(`SDSF_MODE_EQ, 32'h0000_0301, 32'h0000_0301);
    res(5);
    bus(1'h0, 12'h014, 32'h0);
    chk(rd & 32'h6, 32'h4);
    chk({24'h0, cmpAlert}, 32'h1);
    $display("test compare done");
  endtask
  task automatic t_fifo;
    int n;
    run <= 1'h0;
    wr(12'h000, 32'h0);
    bus(1'h0, 12'h104, 32'h0);
    while (rd[31] === 1'h1)
    begin
      bus(1'h0, 12'h100, 32'h0);
      bus(1'h0, 12'h104, 32'h0);
    end
    ones <= 1'h1;
    man  <= 1'h0;
    for (int c = 0; c < 8; c++)
    begin
      wr(12'(c * 32 + 4), 32'h0000_0001);
      wr(12'(c * 32), 32'h0000_0501);
    end
    run <= 1'h1;
    // reader stalls until the buffer refuses, then until a channel overruns
    do bus(1'h0, 12'h104, 32'h0); while (rd[10:5] !== 6'h20);
    chk(rd & 32'h8000_07E0, 32'h8000_0400);
    do bus(1'h0, 12'h014, 32'h0); while (rd[3] !== 1'h1);
    run <= 1'h0;
    for (int c = 0; c < 8; c++)
      wr(12'(c * 32), 32'h0);
    n = 0;
    bus(1'h0, 12'h104, 32'h0);
    while (rd[31] === 1'h1 && n < 40)
    begin
      bus(1'h0, 12'h100, 32'h0);
      bus(1'h0, 12'h104, 32'h0);
      n++;
    end
    chk(rd & 32'h8000_07E0, 32'h0);
    chk({31'h0, n >= 32}, 32'h1);
    $display("test fifo done");
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well past the slow ratio-256 conversions
  initial
  begin
    #450000;
    err_count++;
    stop_test;
  end
  initial
  begin
    rst_b = 1'h0;
    htrans = 2'h0;
    haddr = 12'h0;
    hwrite = 1'h0;
    hwdata = 32'h0;
    run = 1'h0;
    man = 1'h0;
    ones = 1'h1;
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    @(posedge core_clk);
    t_reset;
    t_modes;
    t_orders;
    t_cmp;
    t_fifo;
    stop_test;
  end
endmodule

// file: test/sdsf_mod_model.sv
// behavioural modulator driving eight clock and bit-stream pairs
`timescale 1ns/1ps
module sdsf_mod_model (
  input  wire logic       run,
  input  wire logic       man,
  input  wire logic       ones,
  output logic      [7:0] sdClk,
  output logic      [7:0] sdData
);
  // ---------------------------------------------------------------
  // bit generator, 48 ns per bit
  // ---------------------------------------------------------------
  // odd start offset keeps the link unrelated to the core clock; idle clock stands low
  initial
  begin
    sdClk  = 8'h00;
    sdData = 8'h00;
    #1.3;
    forever
    begin
      if (!run)
      begin
        // manchester idle rests at the first half-bit level, so the first edge is mid-bit
        if (man)
          sdData = {8{!ones}};
        #4;
      end
      else if (man)
      begin
        // clock pin stays still, the value shows at the mid-bit edge
        sdClk  = 8'h00;
        sdData = {8{!ones}};
        #24;
        sdData = {8{ones}};
        #24;
      end
      else
      begin
        // one bit per clock, moved on the falling edge
        sdClk  = 8'hFF;
        #24;
        sdClk  = 8'h00;
        sdData = {8{ones}};
        #24;
      end
    end
  end
endmodule
